// ### dss_regs.svh
// timing counts and encodings for the dual supply sequencer
`ifndef DSS_REGS_SVH
`define DSS_REGS_SVH
`define DSS_MCLK_HZ 25000000
`define DSS_FREQ_LO_HZ 200000
`define DSS_FREQ_HI_HZ 300000
`define DSS_DIV_LO (`DSS_MCLK_HZ / `DSS_FREQ_LO_HZ)
`define DSS_DIV_HI (`DSS_MCLK_HZ / `DSS_FREQ_HI_HZ)
`define DSS_SYNC_MIN_HZ 240000
`define DSS_SYNC_MAX_HZ 350000
`define DSS_SYNC_PER_MAX (`DSS_MCLK_HZ / `DSS_SYNC_MIN_HZ)
`define DSS_SYNC_PER_MIN ((`DSS_MCLK_HZ + `DSS_SYNC_MAX_HZ - 1) / `DSS_SYNC_MAX_HZ)
`define DSS_MIN_OFF_NS 300
`define DSS_MIN_OFF_CYC ((`DSS_MIN_OFF_NS * 25 + 999) / 1000)
`define DSS_PGOOD_CYC 32000
`define DSS_UV_ARM_CYC 6144
`define DSS_SS_FULL_CYC 512
`define DSS_SS_STEPS 5
`define DSS_MAX_SKIP 3
`define DSS_RCL_PWM_MV (-100)
`define DSS_RCL_SKIP_MV 0
`define DSS_ORDER_REF 2'h0
`define DSS_ORDER_VL 2'h1
`define DSS_ORDER_GND 2'h2
`endif

// ### dss_pkg.sv
// types shared by the dual supply sequencer
package dss_pkg;
    typedef enum logic [1:0] {
        DSS_SHUTDOWN = 2'h0,
        DSS_STANDBY = 2'h1,
        DSS_RUN = 2'h2
    } dss_mode_e;
    typedef struct packed {
        logic uv_a;
        logic uv_b;
        logic ov_a;
        logic ov_b;
        logic reg_ok_a;
        logic reg_ok_b;
        logic ilim_a;
        logic ilim_b;
    } dss_cmp_s;
    typedef struct packed {
        logic low_side_drive_a;
        logic low_side_drive_b;
        logic [2:0] ss_step_a;
        logic [2:0] ss_step_b;
        logic en_a;
        logic en_b;
    } dss_drv_s;
endpackage

// ### dss_rail.sv
// per-rail soft-start, undervoltage arming and dropout off-time skip
`timescale 1ns/10ps
`default_nettype none
`include "dss_regs.svh"
module dss_rail (
    // clock and reset
    input wire logic mclk_i,
    input wire logic resetn_i,
    // control
    input wire logic en_i,
    input wire logic osc_tick_i,
    input wire logic out_low_i,
    input wire logic ilim_i,
    // status
    output logic uv_armed_o,
    output logic [2:0] ss_step_o,
    output logic skip_off_o
);
    typedef struct packed {
        logic [12:0] arm_cnt;
        logic [9:0] ss_cnt;
        logic [1:0] skips;
        logic armed;
        logic [2:0] step;
        logic skip;
    } dss_rail_s;
    dss_rail_s st_q, st_d;

    always_comb begin
        st_d = st_q;
        if (!en_i) begin
            st_d = '0;
        end else if (osc_tick_i) begin
            if (st_q.arm_cnt < 13'(`DSS_UV_ARM_CYC)) begin
                st_d.arm_cnt = st_q.arm_cnt + 13'h0001;
            end
            st_d.armed = (st_q.arm_cnt >= 13'(`DSS_UV_ARM_CYC - 1));
            if (st_q.ss_cnt < 10'(`DSS_SS_FULL_CYC)) begin
                st_d.ss_cnt = st_q.ss_cnt + 10'h001;
            end
            // five equal steps across 512 oscillator ticks, last step at full count
            st_d.step = 3'((32'(st_d.ss_cnt) * `DSS_SS_STEPS) / `DSS_SS_FULL_CYC);
            if (out_low_i && !ilim_i && st_q.skips < 2'(`DSS_MAX_SKIP)) begin
                st_d.skips = st_q.skips + 2'h1;
                st_d.skip = 1'b1;
            end else begin
                st_d.skips = 2'h0;
                st_d.skip = 1'b0;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign uv_armed_o = st_q.armed;
    assign ss_step_o = st_q.step;
    assign skip_off_o = st_q.skip;
endmodule // dss_rail
`default_nettype wire

// ### dss_top.sv
// supervisory and sequencing logic of a dual step-down supply controller
`timescale 1ns/10ps
`default_nettype none
`include "dss_regs.svh"
module dss_top (
    // clock and reset
    input wire logic mclk_i,
    input wire logic resetn_i,
    // control pins
    input wire logic freq_sync_i,
    input wire logic power_down_n_i,
    input wire logic [1:0] order_select_i,
    input wire logic master_on_rail_a_i,
    input wire logic delay_on_rail_b_i,
    input wire logic fixed_freq_i,
    input wire logic internal_logic_supply_i,
    input wire logic vin_lost_i,
    // comparator results
    input wire dss_pkg::dss_cmp_s cmp_i,
    // outputs
    output var dss_pkg::dss_drv_s drv_o,
    output logic power_good_o,
    output logic delay_discharge_o,
    output logic osc_tick_o,
    output logic skip_off_a_o,
    output logic skip_off_b_o,
    output logic min_cur_cmp_en_o,
    output logic rev_lim_neg_o,
    output logic [1:0] mode_o
);
    import dss_pkg::*;

    typedef struct packed {
        logic [1:0] sync_sh;
        logic [2:0] sync_h;
        logic [1:0] pd_sh;
        logic [1:0] on_a_sh;
        logic [1:0] on_b_sh;
        logic [1:0] ff_sh;
        logic [1:0] vl_sh;
        logic [1:0] vin_sh;
        dss_cmp_s cmp_s1;
        dss_cmp_s cmp_s2;
        logic [7:0] div_cnt;
        logic [7:0] sync_per;
        logic sync_lock;
        logic tick;
        logic pd_last;
        logic on_last;
        logic uv_latch;
        logic ov_latch;
        logic [14:0] pg_cnt;
        logic pg;
        logic first_pu;
        logic powered;
        logic [1:0] seq_state;
        logic dis;
        dss_drv_s drv;
        logic skip_a;
        logic skip_b;
        logic mincmp;
        logic revneg;
        dss_mode_e mode;
    } dss_top_s;

    dss_top_s st_q, st_d;
    logic uv_armed_a, uv_armed_b, skip_a, skip_b;
    logic [2:0] step_a, step_b;
    logic pd, on_a, on_b, sync_s, seq_ref, a_first;
    logic en_a_raw, en_b_raw, req_a, req_b, fall, fault_clear, any_en;
    logic [7:0] div_lim;

    always_comb begin
        st_d = st_q;
        // two-stage synchronisers, only the second stage is used
        st_d.sync_sh = {st_q.sync_sh[0], freq_sync_i};
        st_d.pd_sh = {st_q.pd_sh[0], power_down_n_i};
        st_d.on_a_sh = {st_q.on_a_sh[0], master_on_rail_a_i};
        st_d.on_b_sh = {st_q.on_b_sh[0], delay_on_rail_b_i};
        st_d.ff_sh = {st_q.ff_sh[0], fixed_freq_i};
        st_d.vl_sh = {st_q.vl_sh[0], internal_logic_supply_i};
        st_d.vin_sh = {st_q.vin_sh[0], vin_lost_i};
        st_d.cmp_s1 = cmp_i;
        st_d.cmp_s2 = st_q.cmp_s1;
        sync_s = st_q.sync_sh[1];
        pd = st_q.pd_sh[1];
        on_a = st_q.on_a_sh[1];
        on_b = st_q.on_b_sh[1];

        // oscillator: level selects rate, falling edge restarts a cycle
        st_d.sync_h = {st_q.sync_h[1:0], sync_s};
        fall = st_q.sync_h[0] && !sync_s;
        div_lim = sync_s ? 8'(`DSS_DIV_HI) : 8'(`DSS_DIV_LO);
        st_d.tick = 1'b0;
        if (st_q.sync_per != 8'hff) begin
            st_d.sync_per = st_q.sync_per + 8'h01;
        end
        if (fall) begin
            // lock only when the measured period lies inside the capture range
            st_d.sync_lock = (st_q.sync_per >= 8'(`DSS_SYNC_PER_MIN - 1))
                && (st_q.sync_per <= 8'(`DSS_SYNC_PER_MAX - 1));
            st_d.sync_per = 8'h00;
            st_d.div_cnt = 8'h00;
            st_d.tick = 1'b1;
        end else if (st_q.div_cnt >= div_lim - 8'h01) begin
            st_d.div_cnt = 8'h00;
            st_d.tick = 1'b1;
        end else begin
            st_d.div_cnt = st_q.div_cnt + 8'h01;
        end
        if (st_q.sync_per == 8'hff) begin
            st_d.sync_lock = 1'b0;
        end

        // mode decode
        seq_ref = (order_select_i == `DSS_ORDER_REF);
        a_first = (order_select_i == `DSS_ORDER_VL);
        if (seq_ref) begin
            en_a_raw = on_a;
            en_b_raw = on_b;
        end else begin
            // delay pin acts as a timing input, high when its capacitor charged
            en_a_raw = on_a && (a_first || on_b);
            en_b_raw = on_a && (!a_first || on_b);
        end
        any_en = seq_ref ? (on_a || on_b) : on_a;
        if (!pd) begin
            st_d.mode = DSS_SHUTDOWN;
        end else if (!any_en) begin
            st_d.mode = DSS_STANDBY;
        end else begin
            st_d.mode = DSS_RUN;
        end

        // fault latches; a set wins over a same-cycle clear
        st_d.pd_last = pd;
        st_d.on_last = on_a;
        fault_clear = (pd != st_q.pd_last) || (on_a != st_q.on_last)
            || st_q.vin_sh[1];
        if ((st_q.cmp_s2.uv_a && uv_armed_a) || (st_q.cmp_s2.uv_b && uv_armed_b)) begin
            st_d.uv_latch = 1'b1;
        end else if (fault_clear) begin
            st_d.uv_latch = 1'b0;
        end
        if (st_q.cmp_s2.ov_a || st_q.cmp_s2.ov_b) begin
            st_d.ov_latch = 1'b1;
        end else if (fault_clear) begin
            st_d.ov_latch = 1'b0;
        end

        req_a = (st_d.mode == DSS_RUN) && en_a_raw && !st_d.uv_latch && !st_d.ov_latch;
        req_b = (st_d.mode == DSS_RUN) && en_b_raw && !st_d.uv_latch && !st_d.ov_latch;
        st_d.drv.en_a = req_a;
        st_d.drv.en_b = req_b;
        st_d.seq_state = {req_b, req_a};
        st_d.drv.ss_step_a = step_a;
        st_d.drv.ss_step_b = step_b;
        // low side held on when off, faulted, or in shutdown with supply alive
        st_d.drv.low_side_drive_a = st_d.ov_latch || st_d.uv_latch || !req_a
            || (st_d.mode == DSS_SHUTDOWN && st_q.vl_sh[1]);
        st_d.drv.low_side_drive_b = st_d.ov_latch || st_d.uv_latch || !req_b
            || (st_d.mode == DSS_SHUTDOWN && st_q.vl_sh[1]);

        // delay pin discharge
        st_d.powered = 1'b1;
        st_d.first_pu = !st_q.powered;
        st_d.dis = (st_d.mode != DSS_RUN) || st_q.first_pu;

        // power-good delay counted in oscillator ticks
        if (!(st_q.cmp_s2.reg_ok_a && (seq_ref || st_q.cmp_s2.reg_ok_b))
            || !req_a) begin
            st_d.pg_cnt = 15'h0000;
            st_d.pg = 1'b0;
        end else if (st_q.tick) begin
            if (st_q.pg_cnt < 15'(`DSS_PGOOD_CYC)) begin
                st_d.pg_cnt = st_q.pg_cnt + 15'h0001;
            end
            st_d.pg = (st_q.pg_cnt >= 15'(`DSS_PGOOD_CYC - 1));
        end

        // light-load behaviour from the fixed-frequency select
        st_d.mincmp = !st_q.ff_sh[1];
        st_d.mincmp = st_d.mincmp;
        st_d.revneg = st_q.ff_sh[1];
        st_d.skip_a = skip_a;
        st_d.skip_b = skip_b;
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_q <= '0;
            st_q.drv.low_side_drive_a <= 1'b1;
            st_q.drv.low_side_drive_b <= 1'b1;
            st_q.dis <= 1'b1;
            st_q.mincmp <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    dss_rail u_rail_a (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .en_i(st_q.drv.en_a),
        .osc_tick_i(st_q.tick),
        .out_low_i(!st_q.cmp_s2.reg_ok_a),
        .ilim_i(st_q.cmp_s2.ilim_a),
        .uv_armed_o(uv_armed_a),
        .ss_step_o(step_a),
        .skip_off_o(skip_a)
    );
    dss_rail u_rail_b (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .en_i(st_q.drv.en_b),
        .osc_tick_i(st_q.tick),
        .out_low_i(!st_q.cmp_s2.reg_ok_b),
        .ilim_i(st_q.cmp_s2.ilim_b),
        .uv_armed_o(uv_armed_b),
        .ss_step_o(step_b),
        .skip_off_o(skip_b)
    );

    assign drv_o = st_q.drv;
    assign power_good_o = st_q.pg;
    assign delay_discharge_o = st_q.dis;
    assign osc_tick_o = st_q.tick;
    assign skip_off_a_o = st_q.skip_a;
    assign skip_off_b_o = st_q.skip_b;
    assign min_cur_cmp_en_o = st_q.mincmp;
    assign rev_lim_neg_o = st_q.revneg;
    assign mode_o = st_q.mode;
endmodule // dss_top
`default_nettype wire

// ### dss_top_sva.sv
// port assertions for the dual supply sequencer
`timescale 1ns/10ps
`default_nettype none
`include "dss_regs.svh"
module dss_top_sva (
    // clock and reset
    input wire logic mclk_i,
    input wire logic resetn_i,
    // pins
    input wire logic power_down_n_i,
    input wire logic [1:0] order_select_i,
    input wire logic master_on_rail_a_i,
    input wire logic delay_on_rail_b_i,
    input wire logic fixed_freq_i,
    input wire logic internal_logic_supply_i,
    input wire dss_pkg::dss_cmp_s cmp_i,
    // outputs
    input wire dss_pkg::dss_drv_s drv_o,
    input wire logic power_good_o,
    input wire logic delay_discharge_o,
    input wire logic osc_tick_o,
    input wire logic min_cur_cmp_en_o,
    input wire logic rev_lim_neg_o,
    input wire logic [1:0] mode_o
);
    import dss_pkg::*;
    logic [7:0] gap_q;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);
    // gap only counts in run, the oscillator may rest in standby or shutdown
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) gap_q <= 8'h00;
        else gap_q <= (osc_tick_o || mode_o != DSS_RUN) ? 8'h00 : gap_q + 8'h01;
    end
    a_shutdown_off: assert property (!power_down_n_i [*4] |->
        mode_o == DSS_SHUTDOWN && !drv_o.en_a && !drv_o.en_b) else $error("shutdown ignored");
    a_standby_idle: assert property ((power_down_n_i && !master_on_rail_a_i
        && (order_select_i != `DSS_ORDER_REF || !delay_on_rail_b_i)) [*4]
        |-> mode_o == DSS_STANDBY && delay_discharge_o) else $error("standby wrong");
    a_fixed_mode: assert property ($stable(fixed_freq_i) [*5] |->
        rev_lim_neg_o == fixed_freq_i && min_cur_cmp_en_o == !fixed_freq_i)
        else $error("fixed mode outputs wrong");
    a_low_side_off: assert property ((!drv_o.en_a && internal_logic_supply_i) [*3] |->
        drv_o.low_side_drive_a) else $error("low side not held");
    a_pg_rails: assert property ((!cmp_i.reg_ok_a || (order_select_i != `DSS_ORDER_REF
        && !cmp_i.reg_ok_b)) [*4] |-> !power_good_o) else $error("power good early");
    a_tick_gap: assert property (int'(gap_q) <= `DSS_DIV_LO + 4)
        else $error("oscillator tick missing");
    a_ov_latch: assert property ((cmp_i.ov_a || cmp_i.ov_b) |-> ##[1:4]
        (drv_o.low_side_drive_a && drv_o.low_side_drive_b)) else $error("overvoltage not clamped");
    // rail counter clears one edge after the enable drops, the step output one edge later
    a_ss_cleared: assert property ((mode_o != DSS_RUN) [*3] |->
        drv_o.ss_step_a == 3'h0 && drv_o.ss_step_b == 3'h0) else $error("soft-start not cleared");
    c_both_on: cover property (drv_o.en_a && drv_o.en_b);
    c_ss_full: cover property (drv_o.ss_step_a == 3'h5);
    c_ov_clamp: cover property (cmp_i.ov_a ##3 drv_o.low_side_drive_b);
endmodule // dss_top_sva
bind dss_top dss_top_sva u_sva (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .power_down_n_i(power_down_n_i),
    .order_select_i(order_select_i), .master_on_rail_a_i(master_on_rail_a_i),
    .delay_on_rail_b_i(delay_on_rail_b_i), .fixed_freq_i(fixed_freq_i),
    .internal_logic_supply_i(internal_logic_supply_i), .cmp_i(cmp_i), .drv_o(drv_o),
    .power_good_o(power_good_o), .delay_discharge_o(delay_discharge_o),
    .osc_tick_o(osc_tick_o), .min_cur_cmp_en_o(min_cur_cmp_en_o),
    .rev_lim_neg_o(rev_lim_neg_o), .mode_o(mode_o)
);
`default_nettype wire

// ### dss_stage_model.sv
// behavioural power stage, comparators and timing capacitor
`timescale 1ns/10ps
`default_nettype none
module dss_stage_model #(
    parameter int RAMP_CYC = 16,
    parameter int CAP_CYC = 200
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic resetn_i,
    // from the sequencer
    input wire dss_pkg::dss_drv_s drv_i,
    input wire logic delay_discharge_i,
    // fault commands
    input wire logic uv_cmd_i,
    input wire logic ov_cmd_i,
    // to the sequencer
    output var dss_pkg::dss_cmp_s cmp_o,
    output logic delay_pin_o
);
    import dss_pkg::*;
    int ramp_a;
    int ramp_b;
    int cap;
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ramp_a <= 0;
            ramp_b <= 0;
            cap <= 0;
        end else begin
            // a clamped rail drops to ground at once, so it never reads regulated
            ramp_a <= (drv_i.en_a && !drv_i.low_side_drive_a) ? ramp_a + int'(ramp_a < RAMP_CYC) : 0;
            ramp_b <= (drv_i.en_b && !drv_i.low_side_drive_b) ? ramp_b + int'(ramp_b < RAMP_CYC) : 0;
            cap <= delay_discharge_i ? 0 : cap + int'(cap < CAP_CYC);
        end
    end
    always_comb begin
        cmp_o = '0;
        cmp_o.uv_a = uv_cmd_i;
        cmp_o.uv_b = uv_cmd_i;
        cmp_o.ov_a = ov_cmd_i;
        cmp_o.reg_ok_a = ramp_a == RAMP_CYC;
        cmp_o.reg_ok_b = ramp_b == RAMP_CYC;
    end
    assign delay_pin_o = cap == CAP_CYC;
endmodule // dss_stage_model
`default_nettype wire

// ### dss_top_bench.sv
// self-checking bench for the dual supply sequencer
`timescale 1ns/10ps
`default_nettype none
`include "dss_regs.svh"
module dss_top_bench;
    import dss_pkg::*;
    typedef struct packed {
        logic [5:0] pins;
        logic [1:0] mode;
        logic [1:0] en;
    } dss_row_s;
    logic mclk, resetn, pd, on_a, on_b, on_b_pin, fix, sync, uv_cmd, ov_cmd, pin, vin;
    logic pg, dis, tick, mce, rln;
    logic [1:0] ord;
    logic [1:0] mode;
    dss_cmp_s cmp;
    dss_drv_s drv;
    int failures = 0;
    int num_checks = 0;
    int n;
    int k;
    // pins are power-down, order select, on a, on b, fixed frequency
    dss_row_s rows [6] = '{'{6'h0c, 2'h0, 2'h0}, '{6'h21, 2'h1, 2'h0}, '{6'h24, 2'h2, 2'h2},
        '{6'h23, 2'h2, 2'h1}, '{6'h26, 2'h2, 2'h3}, '{6'h31, 2'h1, 2'h0}};
    // on b is a plain input only with order at reference, else it is the capacitor
    assign on_b_pin = (ord == `DSS_ORDER_REF) ? on_b : pin;
    dss_top u_dut (
        .mclk_i(mclk), .resetn_i(resetn), .freq_sync_i(sync), .power_down_n_i(pd),
        .order_select_i(ord), .master_on_rail_a_i(on_a), .delay_on_rail_b_i(on_b_pin),
        .fixed_freq_i(fix), .internal_logic_supply_i(1'h1), .vin_lost_i(vin), .cmp_i(cmp),
        .drv_o(drv), .power_good_o(pg), .delay_discharge_o(dis), .osc_tick_o(tick),
        .skip_off_a_o(), .skip_off_b_o(), .min_cur_cmp_en_o(mce), .rev_lim_neg_o(rln),
        .mode_o(mode)
    );
    dss_stage_model u_stage (.mclk_i(mclk), .resetn_i(resetn), .drv_i(drv),
        .delay_discharge_i(dis), .uv_cmd_i(uv_cmd), .ov_cmd_i(ov_cmd), .cmp_o(cmp),
        .delay_pin_o(pin));
    initial begin
        mclk = 1'h0;
        forever #20 mclk = ~mclk;
    end
    task automatic cyc(input int c);
        repeat (c) @(negedge mclk);
    endtask
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // clocks between two ticks, after waiting for the first
    task automatic gap(output int g);
        g = 1;
        for (int i = 0; i < 200 && !tick; i++) cyc(1);
        cyc(1);
        while (!tick && g < 200) begin
            g++;
            cyc(1);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        cyc(70000);
        failures++;
        $display("watchdog expired");
        tally_and_finish();
    end
    initial begin
        {resetn, pd, on_a, on_b, fix, sync, uv_cmd, ov_cmd, vin} = 9'h000;
        ord = 2'h0;
        cyc(1);
        check("reset outputs", 16'h0078, {drv.low_side_drive_a, drv.low_side_drive_b, dis, mce, pg, mode});
        cyc(1);
        resetn = 1'h1;
        $display("test reset done");
        foreach (rows[i]) begin
            {pd, ord, on_a, on_b, fix} = rows[i].pins;
            cyc(8);
            check("mode", rows[i].mode, mode);
            check("enables", rows[i].en, {drv.en_a, drv.en_b});
            check("low side", {!rows[i].en[1], !rows[i].en[0]}, {drv.low_side_drive_a, drv.low_side_drive_b});
            check("fixed", {fix, !fix}, {rln, mce});
        end
        $display("test modes done");
        {ord, on_a, fix} = 4'h1;
        for (k = 0; k < 2; k++) begin
            sync = k[0];
            gap(n);
            gap(n);
            check("tick gap", k ? 16'(`DSS_DIV_HI) : 16'(`DSS_DIV_LO), 16'(n));
        end
        fork
            repeat (6) begin
                sync = 1'h1;
                cyc(40);
                sync = 1'h0;
                cyc(40);
            end
            begin
                cyc(130);
                gap(n);
            end
        join
        check("sync gap", 16'h0050, 16'(n));
        $display("test oscillator done");
        for (k = 0; k < 2; k++) begin
            on_a = 1'h0;
            ord = k ? `DSS_ORDER_GND : `DSS_ORDER_VL;
            cyc(20);
            on_a = 1'h1;
            cyc(8);
            check("first rail", k ? 16'h0001 : 16'h0002, {drv.en_a, drv.en_b});
            for (n = 0; n < 400 && !(drv.en_a && drv.en_b); n++) cyc(1);
            check("rail delay", 16'h0001, 16'(n > 150 && n < 400));
            cyc(300);
            check("power good held", 16'h0000, 16'(pg));
        end
        $display("test sequence done");
        sync = 1'h1;
        on_a = 1'h0;
        cyc(20);
        check("soft-start clear", 16'h0000, {drv.ss_step_a, drv.ss_step_b});
        on_a = 1'h1;
        k = 0;
        while (drv.ss_step_a != 3'h5 && k < 700) begin
            cyc(1);
            k += int'(tick & drv.en_a);
        end
        check("soft-start ticks", 16'h0001, 16'(k >= 511 && k <= 513));
        $display("test softstart done");
        uv_cmd = 1'h1;
        cyc(20);
        uv_cmd = 1'h0;
        check("unarmed uv", 16'h0003, {drv.en_a, drv.en_b});
        ov_cmd = 1'h1;
        cyc(10);
        ov_cmd = 1'h0;
        cyc(50);
        check("ov latch", 16'h0003, {drv.low_side_drive_a, drv.low_side_drive_b});
        on_a = 1'h0;
        cyc(10);
        on_a = 1'h1;
        cyc(400);
        check("ov cleared", 16'h0000, {drv.low_side_drive_a, drv.low_side_drive_b});
        ov_cmd = 1'h1;
        cyc(10);
        ov_cmd = 1'h0;
        cyc(20);
        check("ov relatched", 16'h0003, {drv.low_side_drive_a, drv.low_side_drive_b});
        vin = 1'h1;
        cyc(10);
        vin = 1'h0;
        cyc(20);
        check("ov input lost", 16'h0000, {drv.low_side_drive_a, drv.low_side_drive_b});
        $display("test faults done");
        tally_and_finish();
    end
endmodule // dss_top_bench
`default_nettype wire
